// ---- common/adcdma_pkg.sv ----
// Shared constants and types for the converter capture controller
package adcdma_pkg;
  // Timing control register field positions
  localparam int TC_MODE_HI_BIT = 7;
  localparam int TC_MODE_LO_BIT = 6;
  localparam int TC_EXT_REF_BIT = 6;
  localparam int TC_DIV_HI_BIT = 5;
  localparam int TC_DIV_LO_BIT = 4;
  localparam int TC_ACQ_HI_BIT = 3;
  localparam int TC_ACQ_LO_BIT = 2;
  // Channel control register field positions
  localparam int CC_CAPTURE_BIT = 6;
  // Reset values of the control registers
  localparam logic [7:0] TC_RESET = 8'h00;
  localparam logic [7:0] CC_RESET = 8'h00;
  // Conversion timing in converter clocks
  localparam logic [4:0] CONV_CLOCKS = 5'h0F;
  localparam logic [4:0] SYNC_CLOCKS = 5'h01;
  // Channel code that terminates the list, and the temperature channel code
  localparam logic [3:0] STOP_CODE = 4'hF;
  localparam logic [3:0] TEMP_CODE = 4'h8;
  // Divide ratios selected by the two divider bits
  localparam logic [5:0] DIV_00 = 6'h01;
  localparam logic [5:0] DIV_01 = 6'h02;
  localparam logic [5:0] DIV_10 = 6'h04;
  localparam logic [5:0] DIV_11 = 6'h08;
  // Pipeline depth before the first valid write
  localparam logic [1:0] PIPE_FILL = 2'h3;

  // External memory request carrier
  typedef struct packed {
    logic [23:0] addr;
    logic [7:0] wdata;
    logic we;
    logic oe;
  } adcdma_mem_s;

  // Capture sequencer states
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_RUN = 4'b0010,
    ST_DONE = 4'b0100,
    ST_HALT = 4'b1000
  } adcdma_state_e;
endpackage

// ---- core/adcdma_capture.sv ----
// Converter capture controller writing results to external static RAM
module adcdma_capture (
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic [7:0] TIMING_CTRL,
  input wire logic [7:0] CHANNEL_CTRL,
  input wire logic [7:0] PTR_LOW,
  input wire logic [7:0] PTR_HIGH,
  input wire logic [7:0] PTR_PAGE,
  input wire logic START,
  input wire logic CONTINUOUS,
  input wire logic [11:0] ADC_RESULT,
  input wire logic [7:0] MEM_RDATA,
  input wire logic CORE_MEM_REQ,
  input wire adcdma_pkg::adcdma_mem_s CORE_MEM,
  output adcdma_pkg::adcdma_mem_s MEM_OUT,
  output logic EXT_REF_SEL,
  output logic [3:0] ADC_CHANNEL,
  output logic ADC_SAMPLE,
  output logic DONE_FLAG,
  output logic CAPTURE_ACTIVE
);
  logic tick;
  logic powered;
  logic [4:0] cyc_len;
  adcdma_pkg::adcdma_state_e st_reg, st_next;
  logic [4:0] cnt_reg, cnt_next;
  logic [23:0] rd_ptr_reg, rd_ptr_next;
  logic [23:0] wr_ptr_reg, wr_ptr_next;
  logic [3:0] conv_ch_reg, conv_ch_next;
  logic [3:0] fetch_ch_reg, fetch_ch_next;
  logic [3:0] res_ch_reg, res_ch_next;
  logic [11:0] res_reg, res_next;
  logic [1:0] fill_reg, fill_next;
  logic stop_reg, stop_next;
  logic wr_ok;
  adcdma_pkg::adcdma_mem_s mem_next;
  logic ref_next, samp_next, done_next;

  // Total conversion length in converter clocks
  function automatic logic [4:0] conv_len(input logic [1:0] acq);
    conv_len = adcdma_pkg::CONV_CLOCKS + adcdma_pkg::SYNC_CLOCKS + {3'h0, acq} + 5'h01;
  endfunction

  // Converter clock enable
  adcdma_clkdiv u_div (
    .CLK(CLK),
    .RST_B(RST_B),
    .sel(TIMING_CTRL[adcdma_pkg::TC_DIV_HI_BIT:adcdma_pkg::TC_DIV_LO_BIT]),
    .tick(tick)
  );

  assign powered = TIMING_CTRL[adcdma_pkg::TC_MODE_HI_BIT] |
                   TIMING_CTRL[adcdma_pkg::TC_MODE_LO_BIT];
  assign cyc_len = conv_len(TIMING_CTRL[adcdma_pkg::TC_ACQ_HI_BIT:adcdma_pkg::TC_ACQ_LO_BIT]);
  // Writes allowed from the third cycle, once a real result is latched
  assign wr_ok = ({1'b0, fill_reg} + 3'h1) >= {1'b0, adcdma_pkg::PIPE_FILL};

  // Sequencer next state; ST_RUN steps advance on converter clock ticks, START moves out of ST_IDLE (when powered) and ST_HALT at once
  always_comb begin
    st_next = st_reg;
    cnt_next = cnt_reg;
    rd_ptr_next = rd_ptr_reg;
    wr_ptr_next = wr_ptr_reg;
    conv_ch_next = conv_ch_reg;
    fetch_ch_next = fetch_ch_reg;
    res_ch_next = res_ch_reg;
    res_next = res_reg;
    fill_next = fill_reg;
    stop_next = stop_reg;
    samp_next = 1'b0;
    done_next = DONE_FLAG;
    mem_next = MEM_OUT;
    ref_next = TIMING_CTRL[adcdma_pkg::TC_EXT_REF_BIT];
    if (!CHANNEL_CTRL[adcdma_pkg::CC_CAPTURE_BIT]) begin
      st_next = adcdma_pkg::ST_IDLE;
      rd_ptr_next = {PTR_PAGE, PTR_HIGH, PTR_LOW};
      wr_ptr_next = {PTR_PAGE, PTR_HIGH, PTR_LOW};
      fill_next = 2'h0;
      stop_next = 1'b0;
      cnt_next = 5'h00;
      mem_next = CORE_MEM_REQ ? CORE_MEM : '0;
    end else begin
      mem_next = '0;
      unique case (st_reg)
        adcdma_pkg::ST_IDLE: begin
          if (powered && START) begin
            st_next = adcdma_pkg::ST_RUN;
            cnt_next = 5'h00;
          end
        end
        adcdma_pkg::ST_RUN: begin
          if (tick) begin
            cnt_next = cnt_reg + 5'h01;
            if (cnt_reg == 5'h00) begin
              samp_next = 1'b1;
              mem_next.addr = rd_ptr_reg;
              mem_next.oe = 1'b1;
            end else if (cnt_reg == 5'h02) begin
              fetch_ch_next = MEM_RDATA[7:4];
              rd_ptr_next = rd_ptr_reg + 24'h000002;
            end else if (cnt_reg == 5'h04 && wr_ok) begin
              mem_next.addr = wr_ptr_reg;
              mem_next.wdata = {res_ch_reg, res_reg[11:8]};
              mem_next.we = 1'b1;
            end else if (cnt_reg == 5'h06 && wr_ok) begin
              mem_next.addr = wr_ptr_reg + 24'h000001;
              mem_next.wdata = res_reg[7:0];
              mem_next.we = 1'b1;
              wr_ptr_next = wr_ptr_reg + 24'h000002;
            end
            if (cnt_reg + 5'h01 >= cyc_len) begin
              cnt_next = 5'h00;
              res_next = ADC_RESULT;
              res_ch_next = conv_ch_reg;
              conv_ch_next = fetch_ch_reg;
              if (fill_reg != adcdma_pkg::PIPE_FILL) begin
                fill_next = fill_reg + 2'h1;
              end
              if (fetch_ch_reg == adcdma_pkg::STOP_CODE) begin
                stop_next = 1'b1;
              end
              if (stop_next) begin
                st_next = adcdma_pkg::ST_DONE;
              end else if (!CONTINUOUS && fill_reg == adcdma_pkg::PIPE_FILL) begin
                st_next = adcdma_pkg::ST_HALT;
              end
            end
          end
        end
        adcdma_pkg::ST_HALT: begin
          if (START) begin
            st_next = adcdma_pkg::ST_RUN;
          end
        end
        adcdma_pkg::ST_DONE: begin
          done_next = 1'b1;
        end
        default: st_next = adcdma_pkg::ST_IDLE;
      endcase
    end
    if (START && st_reg == adcdma_pkg::ST_IDLE && !CHANNEL_CTRL[adcdma_pkg::CC_CAPTURE_BIT]) begin
      done_next = 1'b0;
    end
  end

  // Register stage
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      st_reg <= adcdma_pkg::ST_IDLE;
      cnt_reg <= 5'h00;
      rd_ptr_reg <= 24'h000000;
      wr_ptr_reg <= 24'h000000;
      conv_ch_reg <= 4'h0;
      fetch_ch_reg <= 4'h0;
      res_ch_reg <= 4'h0;
      res_reg <= 12'h000;
      fill_reg <= 2'h0;
      stop_reg <= 1'b0;
      MEM_OUT <= '0;
      EXT_REF_SEL <= 1'b0;
      ADC_SAMPLE <= 1'b0;
      DONE_FLAG <= 1'b0;
      ADC_CHANNEL <= 4'h0;
      CAPTURE_ACTIVE <= 1'b0;
    end else begin
      st_reg <= st_next;
      cnt_reg <= cnt_next;
      rd_ptr_reg <= rd_ptr_next;
      wr_ptr_reg <= wr_ptr_next;
      conv_ch_reg <= conv_ch_next;
      fetch_ch_reg <= fetch_ch_next;
      res_ch_reg <= res_ch_next;
      res_reg <= res_next;
      fill_reg <= fill_next;
      stop_reg <= stop_next;
      MEM_OUT <= mem_next;
      EXT_REF_SEL <= ref_next;
      ADC_SAMPLE <= samp_next;
      DONE_FLAG <= done_next;
      ADC_CHANNEL <= conv_ch_next;
      CAPTURE_ACTIVE <= CHANNEL_CTRL[adcdma_pkg::CC_CAPTURE_BIT];
    end
  end

  // Core traffic never reaches memory while capture owns the bus
  AST_CORE_GATED: assert property (@(posedge CLK) disable iff (!RST_B)
    CHANNEL_CTRL[adcdma_pkg::CC_CAPTURE_BIT] |=> (MEM_OUT == '0) || (st_reg == adcdma_pkg::ST_RUN))
    else $error("core access leaked during capture");
  AST_REF_FOLLOWS: assert property (@(posedge CLK) disable iff (!RST_B)
    1'b1 |=> EXT_REF_SEL == $past(TIMING_CTRL[adcdma_pkg::TC_EXT_REF_BIT]))
    else $error("reference select mismatch");
  AST_DIV4: assert property (@(posedge CLK) disable iff (!RST_B)
    (tick && TIMING_CTRL[5:4] == 2'b10 && $stable(TIMING_CTRL)) |=> !tick [*3] ##1 tick)
    else $error("divide by four wrong");
  AST_CYCLE_LEN: assert property (@(posedge CLK) disable iff (!RST_B)
    (st_reg == adcdma_pkg::ST_RUN) |-> cnt_reg < cyc_len)
    else $error("conversion count overran");
  AST_DISABLE: assert property (@(posedge CLK) disable iff (!RST_B)
    !CHANNEL_CTRL[adcdma_pkg::CC_CAPTURE_BIT] |=> st_reg == adcdma_pkg::ST_IDLE)
    else $error("capture not disabled");
  AST_NO_EARLY_WRITE: assert property (@(posedge CLK) disable iff (!RST_B)
    (st_reg == adcdma_pkg::ST_RUN && !wr_ok) |=> !MEM_OUT.we)
    else $error("write before pipeline filled");
  AST_DONE_SET: assert property (@(posedge CLK) disable iff (!RST_B)
    (st_reg == adcdma_pkg::ST_DONE && CHANNEL_CTRL[adcdma_pkg::CC_CAPTURE_BIT]) |=> DONE_FLAG)
    else $error("done flag not set");
  AST_STOP_END: assert property (@(posedge CLK) disable iff (!RST_B)
    (st_reg == adcdma_pkg::ST_DONE) |=> !MEM_OUT.we)
    else $error("write after stop");
endmodule

// ---- core/adcdma_clkdiv.sv ----
// Converter clock enable generator with selectable divide ratio
module adcdma_clkdiv (
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic [1:0] sel,
  output logic tick
);
  logic [5:0] cnt_reg;
  logic [5:0] cnt_next;
  logic tick_next;
  logic [5:0] ratio;

  // Ratio lookup and counter update
  always_comb begin
    unique case (sel)
      2'b00: ratio = adcdma_pkg::DIV_00;
      2'b01: ratio = adcdma_pkg::DIV_01;
      2'b10: ratio = adcdma_pkg::DIV_10;
      2'b11: ratio = adcdma_pkg::DIV_11;
    endcase
    if (cnt_reg + 6'h01 >= ratio) begin
      cnt_next = 6'h00;
      tick_next = 1'b1;
    end else begin
      cnt_next = cnt_reg + 6'h01;
      tick_next = 1'b0;
    end
  end

  // Register stage
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      cnt_reg <= 6'h00;
      tick <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      tick <= tick_next;
    end
  end
endmodule

// ---- testbench/adc_dma_capture_controller_tb.sv ----
// Self-checking bench for the converter capture controller
module adc_dma_capture_controller_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] tc = 8'h00, cc = 8'h00, p_lo = 8'h00, p_hi = 8'h00, p_pg = 8'h00;
  logic start = 1'b0;
  logic cont = 1'b0;
  logic [11:0] adc_res = 12'h000;
  logic core_req = 1'b0;
  adcdma_pkg::adcdma_mem_s core_mem = '0;
  adcdma_pkg::adcdma_mem_s mem_out;
  logic [7:0] rdata;
  logic ext_ref, sample, done, active, addr_bad;
  logic [3:0] chan;
  int n_fail = 0;
  int check_count = 0;
  int n_samples = 0;
  int first_wr = -1;
  always #20 clk = ~clk;
  adcdma_capture i_adcdma_capture (.CLK(clk), .RST_B(rst_b), .TIMING_CTRL(tc),
    .CHANNEL_CTRL(cc), .PTR_LOW(p_lo), .PTR_HIGH(p_hi), .PTR_PAGE(p_pg), .START(start),
    .CONTINUOUS(cont), .ADC_RESULT(adc_res), .MEM_RDATA(rdata), .CORE_MEM_REQ(core_req),
    .CORE_MEM(core_mem), .MEM_OUT(mem_out), .EXT_REF_SEL(ext_ref), .ADC_CHANNEL(chan),
    .ADC_SAMPLE(sample), .DONE_FLAG(done), .CAPTURE_ACTIVE(active));
  adcdma_sram_model i_adcdma_sram_model (.clk(clk), .mem_out(mem_out), .rdata(rdata),
    .addr_bad(addr_bad));
  // Converter stand-in and pipeline fill monitor
  always @(posedge clk) begin
    adc_res <= {chan, tc};
    if (sample === 1'b1) n_samples <= n_samples + 1;
    if (mem_out.we === 1'b1 && first_wr < 0) first_wr <= n_samples;
  end
  // Compare and count
  task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Verdict and end of run
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // Core write request of one cycle
  task automatic core_write(logic [23:0] a);
    @(posedge clk);
    core_mem <= '{addr: a, wdata: 8'hEE, we: 1'b1, oe: 1'b0};
    core_req <= 1'b1;
    @(posedge clk);
    core_req <= 1'b0;
  endtask
  // One full capture of the preset list with given timing
  task automatic run(logic [7:0] timing, int period);
    int gap;
    @(posedge clk);
    cc <= 8'h00;
    tc <= 8'h00;
    @(posedge clk);
    start <= 1'b1;
    p_lo <= 8'h10;
    @(posedge clk);
    start <= 1'b0;
    p_hi <= 8'h34;
    @(posedge clk);
    p_pg <= 8'h12;
    @(posedge clk);
    cc <= 8'h40;
    n_samples <= 0;
    first_wr <= -1;
    check("done cleared", done, 1'b0);
    @(posedge clk);
    tc <= timing;
    cont <= 1'b1;
    @(posedge clk);
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    core_write(24'h123428);
    for (gap = 0; gap < 600 && sample !== 1'b1; gap++) @(negedge clk);
    for (gap = 1; gap < 600; gap++) begin
      @(negedge clk);
      if (sample === 1'b1) break;
    end
    check("sample period", 16'(gap), 16'(period));
    check("capture active", active, 1'b1);
    for (gap = 0; gap < 4000 && done !== 1'b1; gap++) @(negedge clk);
    check("done flag", done, 1'b1);
    check("fill samples", 16'(first_wr), 16'h0003);
    for (int i = 0; i < 4; i++) begin
      gap = i_adcdma_sram_model.IDS[i];
      check("entry byte0", i_adcdma_sram_model.mem[16 + 2 * i], {gap[3:0], gap[3:0]});
      check("entry byte1", i_adcdma_sram_model.mem[17 + 2 * i], timing);
    end
    check("repeat entry", {i_adcdma_sram_model.mem[24], i_adcdma_sram_model.mem[25]}, 16'h3000);
    check("stop entry", {i_adcdma_sram_model.mem[26], i_adcdma_sram_model.mem[27]}, 16'hF000);
    check("address page", addr_bad, 1'b0);
    check("gated core write", i_adcdma_sram_model.mem[40], 8'h00);
  endtask
  // Main sequence
  initial begin
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    tc <= 8'h40;
    repeat (3) @(negedge clk);
    check("ext reference", ext_ref, 1'b1);
    @(posedge clk);
    tc <= 8'h80;
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    repeat (40) @(negedge clk);
    check("ext reference", ext_ref, 1'b0);
    check("refused start", active, 1'b0);
    run(8'h80, 17);
    run(8'hAC, 80);
    @(posedge clk);
    cc <= 8'h00;
    repeat (4) @(posedge clk);
    core_write(24'h123429);
    repeat (4) @(negedge clk);
    check("core write passes", i_adcdma_sram_model.mem[41], 8'hEE);
    give_verdict();
  end
  // Watchdog
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    give_verdict();
  end
endmodule

// ---- testbench/adcdma_sram_model.sv ----
// Behavioural static RAM on the capture memory bus
module adcdma_sram_model #(
  parameter logic [17:0] UPPER = 18'h048D0,
  parameter int HOLD = 20
) (
  input wire logic clk,
  input wire adcdma_pkg::adcdma_mem_s mem_out,
  output logic [7:0] rdata,
  output logic addr_bad
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [3:0] IDS [6] = '{4'h2, 4'h5, 4'h8, 4'h3, 4'h3, 4'hF};
  logic [7:0] mem [0:63];
  logic [7:0] held = 8'h00;
  int age = HOLD;
  // Channel list preset from index 16, stop pattern last
  initial begin
    addr_bad = 1'b0;
    for (int i = 0; i < 64; i++) mem[i] = 8'h00;
    for (int i = 0; i < 6; i++) mem[16 + 2 * i] = {IDS[i], 4'h0};
  end
  // Store writes, latch read data, flag addresses off the page
  always @(posedge clk) begin
    if (mem_out.we === 1'b1) mem[mem_out.addr[5:0]] <= mem_out.wdata;
    if ((mem_out.we | mem_out.oe) === 1'b1 && mem_out.addr[23:6] !== UPPER) addr_bad <= 1'b1;
    if (mem_out.oe === 1'b1) begin
      held <= mem[mem_out.addr[5:0]];
      age <= 0;
    end else if (age < HOLD) begin
      age <= age + 1;
    end
  end
  // Data bus no longer valid once hold runs out
  assign rdata = (age < HOLD) ? held : ~held;
endmodule
